// ==== battery_protection_control_regs.sv ====
`timescale 1ns/1ps
`include "bp_ctl_regs.svh"
// Overview of operation
// - Monitor enable bit powers current amplifier.
// - Zero bit grounds both amplifier inputs.
// - Gain bit picks ten or fifty.
// - Short detection active only for code 01.
// - Threshold code selects 50 to 400 mV.
// - Short event pulls interrupt line low.
// - Debounce time is code times 32 us.
// - Action bits shut and lock gate drivers.
// - Lock released by control input falling edge.
// - Action bit writable only while control low.
// - Over-temperature enable bit, resets to one.
// - Over-temperature locks balance until cleared.
// - Two-bit code selects temperature trip point.
// - Over-temperature status with hysteresis release.
// - Status shows the three driver states.
// - Wake B after 10 us resets sleep.
// - Wake A after 1 ms, clears below 1.5V.
// - Short status follows the short event.
// - Mask bit suppresses pulse, keeps flag.
// - Flags set on rise, cleared by read.
// - I2C slave at address 1011101.
// - Sleep only for code 01, reset 10.
module battery_protection_control_regs #(
  parameter int DBN_STEP_CYCLES = `DBN_STEP_US * `CLK_MHZ,
  parameter int WAKE_A_CYCLES   = `WAKE_A_MS * `US_PER_MS * `CLK_MHZ,
  parameter int CNT_W           = 18
) (
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  input  wire logic                 scl,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_drive_n,
  input  wire bp_ctl_pkg::gate_ctl_t gate_ctl_in,
  output bp_ctl_pkg::gate_out_t     gate_out,
  input  wire logic                 hv_wake_pin_a,
  input  wire logic                 hv_wake_a_low,
  input  wire logic                 hv_wake_pin_b,
  input  wire logic                 short_cmp,
  input  wire logic                 overtemp_above,
  input  wire logic                 overtemp_below_hys,
  input  wire logic                 balance_cleared,
  output bp_ctl_pkg::amp_cfg_t      amp_cfg,
  output logic                      short_detect_on,
  output logic [2:0]                short_threshold_level,
  output logic                      overtemp_detect_enable,
  output logic [1:0]                overtemp_threshold,
  output logic                      balance_lock,
  output logic                      sleep_reset,
  output logic                      soft_wake,
  output logic                      irq_out_n
);
  import bp_ctl_pkg::*;

  localparam int WAKE_B_CYCLES = `WAKE_B_US * `CLK_MHZ;
  localparam int IRQ_CYCLES    = `IRQ_PULSE_NS * `CLK_MHZ / `NS_PER_US;
  localparam logic [2:0] ACT_RST = `RST_ACT;
  // The bus lines idle high, so the sampled copies start high as well and
  // no false bus edge is seen when reset lets go.
  localparam pins_t PINS_IDLE = '{scl: 1'b1, sda: 1'b1, ctl: '0,
                                  default: 1'b0};

  pins_t            pin_now;
  pins_t            s1;
  pins_t            s2;
  logic             scl_d;
  logic             sda_d;
  logic             scl_rise;
  logic             scl_fall;
  logic             i2c_start;
  logic             i2c_stop;
  i2c_state_t       st;
  logic [3:0]       bitcnt;
  logic [7:0]       shift;
  logic [7:0]       tx;
  logic [7:0]       ptr;
  logic             rw;
  logic             mack;
  logic             wr_stb;
  logic             rd_stb;
  logic [7:0]       rd_data;
  logic [7:0]       cm;
  logic [7:0]       sc1;
  logic [7:0]       sc2;
  logic [2:0]       act;
  logic [7:0]       ot;
  logic [7:0]       mask;
  logic [7:0]       flags;
  logic [7:0]       status;
  logic [7:0]       status_d;
  logic [7:0]       rise;
  logic [2:0]       lock;
  logic [2:0]       drv;
  logic [2:0]       ctl_d;
  logic [CNT_W-1:0] dbn_cnt;
  logic [CNT_W-1:0] dbn_target;
  logic             short_status;
  logic             ot_status;
  logic [CNT_W-1:0] wa_cnt;
  logic [CNT_W-1:0] wb_cnt;
  logic             wake_a_status;
  logic             wake_b_status;
  logic             irq_fire;
  logic [7:0]       irq_cnt;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  assign pin_now = {scl, sda_in, gate_ctl_in, hv_wake_pin_a,
                    hv_wake_a_low, hv_wake_pin_b, short_cmp,
                    overtemp_above, overtemp_below_hys};

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s1    <= PINS_IDLE;
      s2    <= PINS_IDLE;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      ctl_d <= 3'h0;
    end else begin
      s1    <= pin_now;
      s2    <= s1;
      scl_d <= s2.scl;
      sda_d <= s2.sda;
      ctl_d <= s2.ctl;
    end
  end

  assign scl_rise  = s2.scl & ~scl_d;
  assign scl_fall  = ~s2.scl & scl_d;
  assign i2c_start = s2.scl & scl_d & sda_d & ~s2.sda;
  assign i2c_stop  = s2.scl & scl_d & ~sda_d & s2.sda;
  assign sda_out   = 1'b0;

  // ****************************************************************
  // I2C slave
  // ****************************************************************
  // The bus clock is oversampled, so every bus edge is seen as a
  // one-cycle event and the data line is only moved after SCL falls.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st          <= st_idle;
      bitcnt      <= 4'h0;
      shift       <= 8'h00;
      tx          <= 8'h00;
      ptr         <= 8'h00;
      rw          <= 1'b0;
      mack        <= 1'b1;
      wr_stb      <= 1'b0;
      rd_stb      <= 1'b0;
      sda_drive_n <= 1'b1;
    end else begin
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      if (i2c_start) begin
        st          <= st_addr;
        bitcnt      <= 4'h0;
        sda_drive_n <= 1'b1;
      end else if (i2c_stop) begin
        st          <= st_idle;
        sda_drive_n <= 1'b1;
      end else if (scl_rise) begin
        case (st)
          st_addr, st_ptr, st_wr: begin
            shift  <= {shift[6:0], s2.sda};
            bitcnt <= bitcnt + 4'h1;
          end
          st_rd: begin
            bitcnt <= bitcnt + 4'h1;
          end
          st_rd_ack: begin
            mack <= s2.sda;
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (st)
          st_addr: begin
            if (bitcnt == `BYTE_BITS) begin
              if (shift[7:1] == `I2C_ADDR) begin
                st          <= st_addr_ack;
                rw          <= shift[0];
                sda_drive_n <= 1'b0;
              end else begin
                st <= st_idle;
              end
            end
          end
          st_addr_ack, st_rd_ack: begin
            bitcnt <= 4'h0;
            if ((st == st_addr_ack && rw) ||
                (st == st_rd_ack && !mack)) begin
              st          <= st_rd;
              tx          <= {rd_data[6:0], 1'b0};
              sda_drive_n <= rd_data[7];
              rd_stb      <= (ptr == `OFS_FLAG);
            end else begin
              st          <= (st == st_addr_ack) ? st_ptr : st_idle;
              sda_drive_n <= 1'b1;
            end
          end
          st_ptr: begin
            if (bitcnt == `BYTE_BITS) begin
              st          <= st_ptr_ack;
              ptr         <= shift;
              sda_drive_n <= 1'b0;
            end
          end
          st_wr: begin
            if (bitcnt == `BYTE_BITS) begin
              st          <= st_wr_ack;
              wr_stb      <= 1'b1;
              sda_drive_n <= 1'b0;
            end
          end
          st_ptr_ack, st_wr_ack: begin
            if (st == st_wr_ack) begin
              ptr <= ptr + 8'h01;
            end
            st          <= st_wr;
            bitcnt      <= 4'h0;
            sda_drive_n <= 1'b1;
          end
          st_rd: begin
            if (bitcnt == `BYTE_BITS) begin
              st          <= st_rd_ack;
              ptr         <= ptr + 8'h01;
              sda_drive_n <= 1'b1;
            end else begin
              tx          <= {tx[6:0], 1'b0};
              sda_drive_n <= tx[7];
            end
          end
          default: begin
            st <= st_idle;
          end
        endcase
      end
    end
  end

  always_comb begin
    case (ptr)
      `OFS_CM:   rd_data = cm;
      `OFS_SC1:  rd_data = sc1;
      `OFS_SC2:  rd_data = sc2;
      `OFS_ACT:  rd_data = {5'h00, act};
      `OFS_OT:   rd_data = ot;
      `OFS_STAT: rd_data = status;
      `OFS_MASK: rd_data = mask;
      `OFS_FLAG: rd_data = flags;
      default:   rd_data = 8'h00;
    endcase
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cm        <= `RST_CM;
      sc1       <= `RST_SC1;
      sc2       <= `RST_SC2;
      ot        <= `RST_OT;
      mask      <= `RST_MASK;
      soft_wake <= 1'b0;
    end else if (wr_stb) begin
      case (ptr)
        `OFS_CM:   cm   <= shift & `WM_CM;
        `OFS_SC1:  sc1  <= shift & `WM_SC1;
        `OFS_SC2:  sc2  <= shift & `WM_SC2;
        `OFS_OT:   ot   <= shift & `WM_OT;
        `OFS_MASK: mask <= shift & `WM_MASK;
        `OFS_STAT: soft_wake <= shift[`ST_WA];
        default: begin
        end
      endcase
    end
  end

  assign amp_cfg = {cm[`CM_EN], cm[`CM_ZERO], cm[`CM_GAIN]};
  assign short_detect_on = (sc1[`SC_EN] == `SC_ON);
  assign short_threshold_level = sc1[`SC_TH];
  assign overtemp_detect_enable = ot[`OT_EN];
  assign overtemp_threshold = ot[`OT_TH];

  // ****************************************************************
  // Short-current debounce
  // ****************************************************************
  assign dbn_target = CNT_W'(sc2[`SC_TD] * DBN_STEP_CYCLES);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dbn_cnt      <= '0;
      short_status <= 1'b0;
    end else if (!(short_detect_on && s2.short_cmp)) begin
      dbn_cnt      <= '0;
      short_status <= 1'b0;
    end else if (dbn_cnt >= dbn_target) begin
      short_status <= 1'b1;
    end else begin
      dbn_cnt <= dbn_cnt + 1'b1;
    end
  end

  chk_debounce_zero: assert property (
    short_detect_on && s2.short_cmp && sc2[`SC_TD] == 5'h00
    |=> short_status)
    else $error("short status late with zero debounce");

  chk_short_enable_code: assert property (
    wr_stb && ptr == `OFS_SC1
    |=> short_detect_on == ($past(shift[7:6]) == `SC_ON))
    else $error("short enable code decoded wrongly");

  // ****************************************************************
  // Gate driver lock, one slice per driver
  // ****************************************************************
  // The control inputs come through the synchronisers, so a release
  // edge and the driver state both lag the pin by three cycles.
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gate_slice
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          act[g] <= ACT_RST[g];
        end else if (wr_stb && ptr == `OFS_ACT && !s2.ctl[g]) begin
          act[g] <= shift[g];
        end
      end

      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          lock[g] <= 1'b0;
          drv[g]  <= 1'b0;
        end else begin
          if (short_status && !status_d[`ST_SC] && act[g]) begin
            lock[g] <= 1'b1;
          end else if (ctl_d[g] && !s2.ctl[g]) begin
            lock[g] <= 1'b0;
          end
          drv[g] <= s2.ctl[g] & ~lock[g];
        end
      end

      chk_lock_keeps_off: assert property (
        lock[g] |=> !drv[g])
        else $error("locked gate driver turned on");

      chk_lock_release: assert property (
        lock[g] && !s2.ctl[g] && !ctl_d[g] && !short_status
        |=> lock[g])
        else $error("gate lock dropped without falling edge");

      chk_action_guard: assert property (
        wr_stb && ptr == `OFS_ACT && s2.ctl[g] |=> $stable(act[g]))
        else $error("action bit written while control high");
    end
  endgenerate

  assign gate_out = drv;

  // ****************************************************************
  // Over-temperature and balance lock
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ot_status <= 1'b0;
    end else if (!ot[`OT_EN]) begin
      ot_status <= 1'b0;
    end else if (s2.ot_above) begin
      ot_status <= 1'b1;
    end else if (s2.ot_below_hys) begin
      ot_status <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      balance_lock <= 1'b0;
    end else if (ot_status && !status_d[`ST_OT] && ot[`OT_ACT]) begin
      balance_lock <= 1'b1;
    end else if (balance_cleared) begin
      balance_lock <= 1'b0;
    end
  end

  chk_overtemp_off: assert property (
    !ot[`OT_EN] |=> !ot_status)
    else $error("overtemp status set while disabled");

  chk_balance_hold: assert property (
    balance_lock && !balance_cleared |=> balance_lock)
    else $error("balance lock lost without clearing write");

  // ****************************************************************
  // High-voltage wake detection
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wb_cnt        <= '0;
      wake_b_status <= 1'b0;
    end else if (!s2.wake_b) begin
      wb_cnt        <= '0;
      wake_b_status <= 1'b0;
    end else if (wb_cnt >= CNT_W'(WAKE_B_CYCLES)) begin
      wake_b_status <= 1'b1;
    end else begin
      wb_cnt <= wb_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wa_cnt        <= '0;
      wake_a_status <= 1'b0;
    end else begin
      if (!s2.wake_a) begin
        wa_cnt <= '0;
      end else if (wa_cnt < CNT_W'(WAKE_A_CYCLES)) begin
        wa_cnt <= wa_cnt + 1'b1;
      end
      if (s2.wake_a_low) begin
        wake_a_status <= 1'b0;
      end else if (wa_cnt >= CNT_W'(WAKE_A_CYCLES)) begin
        wake_a_status <= 1'b1;
      end
    end
  end

  // Sleep field itself lives outside; it takes this pulse as a reset
  // to its power-on code, which keeps the part awake.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sleep_reset <= 1'b0;
    end else begin
      sleep_reset <= rise[`ST_WB] | rise[`ST_WA];
    end
  end

  chk_wake_sleep_reset: assert property (
    $rose(wake_b_status) |=> sleep_reset)
    else $error("wake B did not reset sleep control");

  // ****************************************************************
  // Status, flags and interrupt line
  // ****************************************************************
  always_comb begin
    status          = 8'h00;
    status[`ST_DRV] = drv;
    status[`ST_OT]  = ot_status;
    status[`ST_WB]  = wake_b_status;
    status[`ST_WA]  = wake_a_status;
    status[`ST_SC]  = short_status;
  end

  assign rise     = status & ~status_d & `WM_FLAG;
  assign irq_fire = |(rise & ~mask);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      status_d <= 8'h00;
      flags    <= 8'h00;
    end else begin
      status_d <= status;
      flags    <= (flags & ~{8{rd_stb}}) | rise;
    end
  end

  // The line stays low through an unmasked live short as well as for a fixed
  // pulse on each unmasked edge, so an unmasked short cannot be missed.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_cnt   <= 8'h00;
      irq_out_n <= 1'b1;
    end else begin
      if (irq_fire) begin
        irq_cnt <= 8'(IRQ_CYCLES - 1);
      end else if (irq_cnt != 8'h00) begin
        irq_cnt <= irq_cnt - 8'h01;
      end
      irq_out_n <= ~(irq_fire || irq_cnt != 8'h00 ||
                     (short_status && !mask[`ST_SC]));
    end
  end

  chk_irq_pulse_len: assert property (
    irq_fire |=> !irq_out_n [*8])
    else $error("interrupt pulse too short");

  chk_flag_read_clear: assert property (
    rd_stb && rise == 8'h00 |=> flags == 8'h00)
    else $error("flags not cleared by read");

  chk_flag_set_wins: assert property (
    rise[`ST_SC] |=> flags[`ST_SC])
    else $error("short flag lost");

endmodule

// ==== battery_protection_control_regs_test.sv ====
`timescale 1ns/1ps
`include "bp_ctl_regs.svh"
module battery_protection_control_regs_test;
  import bp_ctl_pkg::*;
  logic       clk_sys, resetn, scl, host_pull, sda_out, sda_drive_n, sda;
  gate_ctl_t  gate_ctl_in;
  gate_out_t  gate_out;
  amp_cfg_t   amp_cfg;
  logic       wpa, wal, wpb, short_cmp, ot_up, ot_dn, bal_clr, ack;
  logic       sd_on, otde, bal_lock, sleep_reset, soft_wake, irq_out_n;
  logic [2:0] sc_lvl;
  logic [1:0] ot_th;
  logic [7:0] rx;
  int         err_total, comparisons, low, sr;
  logic [24:0] rows [23] = '{
    25'h0_02_00_00, 25'h0_03_00_81, 25'h0_04_00_01, 25'h0_05_00_03,
    25'h0_06_00_92, 25'h0_07_00_00, 25'h0_08_00_00, 25'h0_09_00_00,
    25'h0_0A_00_00, 25'h1_02_FF_E0, 25'h1_03_FF_C7, 25'h1_04_FF_1F,
    25'h1_05_FF_07, 25'h1_06_FF_93, 25'h1_08_FF_1D, 25'h1_07_FF_00,
    25'h1_07_00_00, 25'h1_09_FF_00, 25'h1_02_A0_A0, 25'h1_03_41_41,
    25'h1_04_02_02, 25'h1_05_03_03, 25'h1_08_00_00};

  // Open-drain data line with a pull-up.
  assign sda = ~(host_pull | ~sda_drive_n);

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  battery_protection_control_regs #(
    .DBN_STEP_CYCLES(4),
    .WAKE_A_CYCLES  (20)
  ) i_battery_protection_control_regs (
    .clk_sys(clk_sys), .resetn(resetn), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_drive_n(sda_drive_n),
    .gate_ctl_in(gate_ctl_in), .gate_out(gate_out),
    .hv_wake_pin_a(wpa), .hv_wake_a_low(wal), .hv_wake_pin_b(wpb),
    .short_cmp(short_cmp), .overtemp_above(ot_up),
    .overtemp_below_hys(ot_dn), .balance_cleared(bal_clr),
    .amp_cfg(amp_cfg), .short_detect_on(sd_on),
    .short_threshold_level(sc_lvl), .overtemp_detect_enable(otde),
    .overtemp_threshold(ot_th), .balance_lock(bal_lock),
    .sleep_reset(sleep_reset), .soft_wake(soft_wake),
    .irq_out_n(irq_out_n));

  i2c_host_model i_i2c_host_model (
    .clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_pull(host_pull));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic x(input logic [7:0] t);
    i_i2c_host_model.xfer(t, rx, ack);
  endtask
  task automatic wr(input logic [7:0] o, input logic [7:0] d);
    i_i2c_host_model.start();
    x({`I2C_ADDR, 1'b0});
    check(ack, 1'b1);
    x(o);
    x(d);
    i_i2c_host_model.stop();
  endtask
  task automatic rd(input logic [7:0] o, input logic [7:0] e);
    i_i2c_host_model.start();
    x({`I2C_ADDR, 1'b0});
    x(o);
    i_i2c_host_model.start();
    x({`I2C_ADDR, 1'b1});
    x(8'hFF);
    i_i2c_host_model.stop();
    check(rx, e);
  endtask
  // Counts low cycles of the interrupt line and sleep reset pulses.
  task automatic watch(input int n);
    low = 0;
    sr = 0;
    repeat (n) begin
      cyc(1);
      if (irq_out_n === 1'b0) low++;
      if (sleep_reset === 1'b1) sr++;
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    {resetn, gate_ctl_in, wpa, wal, wpb, short_cmp} = '0;
    {ot_up, ot_dn, bal_clr} = '0;
    cyc(12);
    resetn = 1'b1;
    cyc(3);
    foreach (rows[i]) begin
      if (rows[i][24]) wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    check(amp_cfg, 3'b101);
    check(sda_out, 1'b0);
    wr(8'h07, 8'h04);
    check(soft_wake, 1'b1);
    wr(8'h07, 8'h00);
    wr(8'h00, 8'h80);
    check(soft_wake, 1'b0);
    check(sc_lvl, 3'd1);
    check({otde, ot_th}, 3'b111);
    for (int c = 0; c < 4; c++) begin
      wr(8'h03, {c[1:0], 6'h01});
      check(sd_on, c == 1);
    end
    i_i2c_host_model.start();
    x({`I2C_ADDR, 1'b0});
    x(8'h02);
    x(8'hE0);
    x(8'h41);
    check(ack, 1'b1);
    i_i2c_host_model.stop();
    rd(8'h02, 8'hE0);
    rd(8'h03, 8'h41);
    gate_ctl_in = 3'b111;
    short_cmp = 1'b1;
    cyc(5);
    short_cmp = 1'b0;
    cyc(20);
    check({irq_out_n, gate_out}, 4'hF);
    short_cmp = 1'b1;
    cyc(30);
    check({irq_out_n, gate_out}, 4'h4);
    rd(8'h07, 8'h81);
    rd(8'h09, 8'h01);
    rd(8'h09, 8'h00);
    short_cmp = 1'b0;
    cyc(60);
    gate_ctl_in = 3'b110;
    cyc(10);
    gate_ctl_in = 3'b111;
    cyc(10);
    check(gate_out, 3'b101);
    wr(8'h05, 8'h00);
    rd(8'h05, 8'h03);
    wr(8'h08, 8'h08);
    wpb = 1'b1;
    watch(2600);
    check({sr[3:0], low[3:0]}, 8'h10);
    rd(8'h09, 8'h08);
    wpa = 1'b1;
    watch(100);
    check(sr[7:0], 8'h01);
    check(low[7:0], 8'h32);
    wpa = 1'b0;
    wal = 1'b1;
    wpb = 1'b0;
    cyc(10);
    rd(8'h07, 8'hA0);
    ot_up = 1'b1;
    cyc(10);
    check(bal_lock, 1'b1);
    ot_up = 1'b0;
    rd(8'h07, 8'hB0);
    ot_dn = 1'b1;
    bal_clr = 1'b1;
    cyc(1);
    bal_clr = 1'b0;
    cyc(5);
    check(bal_lock, 1'b0);
    rd(8'h07, 8'hA0);
    resetn = 1'b0;
    cyc(2);
    check({irq_out_n, gate_out, amp_cfg}, 7'h40);
    check({otde, ot_th, sc_lvl, sd_on}, 7'h62);
    resetn = 1'b1;
    cyc(3);
    rd(8'h05, 8'h03);
    wr(8'h06, 8'h12);
    ot_up = 1'b1;
    gate_ctl_in = 3'b100;
    wr(8'h03, 8'h41);
    wr(8'h04, 8'h00);
    check({otde, bal_lock}, 2'b00);
    short_cmp = 1'b1;
    cyc(8);
    check({irq_out_n, gate_out}, 4'h4);
    rd(8'h07, 8'h81);
    short_cmp = 1'b0;
    cyc(10);
    gate_ctl_in = 3'b111;
    cyc(10);
    check(gate_out, 3'b100);
    report_and_stop();
  end
endmodule

// ==== bp_ctl_pkg.sv ====
package bp_ctl_pkg;

  typedef struct packed {
    logic charge_gate_control_in;
    logic discharge_control_in_b;
    logic discharge_control_in_a;
  } gate_ctl_t;

  typedef struct packed {
    logic charge_gate_output;
    logic discharge_gate_output_b;
    logic discharge_gate_output_a;
  } gate_out_t;

  typedef struct packed {
    logic current_monitor_enable;
    logic amp_inputs_grounded;
    logic gain_select;
  } amp_cfg_t;

  typedef struct packed {
    logic      scl;
    logic      sda;
    gate_ctl_t ctl;
    logic      wake_a;
    logic      wake_a_low;
    logic      wake_b;
    logic      short_cmp;
    logic      ot_above;
    logic      ot_below_hys;
  } pins_t;

  typedef enum logic [3:0] {
    st_idle,
    st_addr,
    st_addr_ack,
    st_ptr,
    st_ptr_ack,
    st_wr,
    st_wr_ack,
    st_rd,
    st_rd_ack
  } i2c_state_t;

endpackage

// ==== bp_ctl_regs.svh ====
`ifndef BP_CTL_REGS_SVH
`define BP_CTL_REGS_SVH

// ****************************************************************
// Bus address and register offsets
// ****************************************************************
`define I2C_ADDR     7'h5D
`define OFS_CM       8'h02
`define OFS_SC1      8'h03
`define OFS_SC2      8'h04
`define OFS_ACT      8'h05
`define OFS_OT       8'h06
`define OFS_STAT     8'h07
`define OFS_MASK     8'h08
`define OFS_FLAG     8'h09

// ****************************************************************
// Reset values and writable bits
// ****************************************************************
`define RST_CM       8'h00
`define RST_SC1      8'h81
`define RST_SC2      8'h01
`define RST_ACT      3'h3
`define RST_OT       8'h92
`define RST_MASK     8'h00
`define WM_CM        8'hE0
`define WM_SC1       8'hC7
`define WM_SC2       8'h1F
`define WM_OT        8'h93
`define WM_MASK      8'h1D
`define WM_FLAG      8'h1D

// ****************************************************************
// Field positions and codes
// ****************************************************************
`define CM_EN        7
`define CM_ZERO      6
`define CM_GAIN      5
`define SC_EN        7:6
`define SC_ON        2'h1
`define SC_TH        2:0
`define SC_TD        4:0
`define ACT_F        2:0
`define OT_EN        7
`define OT_ACT       4
`define OT_TH        1:0
`define ST_DRV       7:5
`define ST_OT        4
`define ST_WB        3
`define ST_WA        2
`define ST_SC        0
`define BYTE_BITS    4'h8

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_MHZ      250
`define US_PER_MS    1000
`define NS_PER_US    1000
`define DBN_STEP_US  32
`define WAKE_B_US    10
`define WAKE_A_MS    1
`define IRQ_PULSE_NS 200

`endif

// ==== i2c_host_model.sv ====
`timescale 1ns/1ps
// *****
// Host side of the two-wire bus, 10 clocks per half period of SCL.
// *****
module i2c_host_model (
  input  wire logic clk_sys,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic half();
    repeat (10) @(posedge clk_sys);
    #1;
  endtask
  // Serves as a repeated start too, so the pointer survives a read.
  task automatic start();
    sda_pull = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_pull = 1'b1;
    half();
    scl = 1'b0;
  endtask
  // The ack slot is always released: single reads end with a NACK.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_pull = ~tx[i];
      half();
      scl = 1'b1;
      half();
      rx[i] = sda;
      scl = 1'b0;
    end
    sda_pull = 1'b0;
    half();
    scl = 1'b1;
    half();
    ack = ~sda;
    scl = 1'b0;
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_pull = 1'b0;
    half();
  endtask
endmodule
